// File: tpom_monitor.sv
// Purpose: Receive path overhead monitor for one tributary, APB register slave
// Assumes: Overhead inputs come from logic on clk_sys; frame_tick marks one
//          multiframe (one frame in TU3 mode) and qualifies every other field except lop, lom and ais
// Notes: APB answers with pready in the second access cycle
//
// Functional notes
// RULE_01: V5 RDI filtered over five or ten multiframes
// RULE_02: TU3 mode takes RDI from G1 bit
// RULE_03: V5 RFI filtered alike; unused in TU3
// RULE_04: Extended code loads after N identical receptions
// RULE_05: Mismatch when accepted differs from expected label
// RULE_06: Unstable counter, asserts at five, clears on stability
// RULE_07: Forced or label-matched path defect indication
// RULE_08: Terminate mode inserts AIS per global enables
// RULE_09: Through mode inserts AIS only on LOP/LOM
// RULE_10: Select picks V5 bits or Z7 code
// RULE_11: TU3 select picks G1 RDI or G1 code
// RULE_12: Compare eight bits in TU3, else three
// RULE_13: Accepted label eight bits TU3, else three
// RULE_14: Trigger write snapshots parity count, restarts count
// RULE_15: Parity count wraps, never saturates
// RULE_16: Outside TU3 upper five count bits zero
// RULE_17: BIP-8 for TU3, BIP-2 otherwise, bit/block
// RULE_18: Block mode adds one per errored block
// RULE_19: Far-end count snapshotted on same trigger
// RULE_20: Remote defect changes flagged when enabled
// RULE_21: Both count bytes captured in one snapshot
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module tpom_monitor (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tpom_pkg::tpom_ovh_t ovh,
    output tpom_pkg::tpom_alarm_t receive_alarm_port,
    output logic remote_defect_irq
);
    import tpom_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : ones8

    function automatic logic [7:0] lbl_mask(input logic tu3, input logic [7:0] v);
        return tu3 ? v : {5'h00, v[2:0]};
    endfunction : lbl_mask

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] cs_q;
    logic [7:0] exp_q;
    logic [7:0] acc_q;
    logic [7:0] own_q;
    logic [7:0] aisc_q;
    logic rdi_q;
    logic rfi_q;
    logic [3:0] rdi_cnt_q;
    logic [3:0] rfi_cnt_q;
    logic [2:0] erdi_q;
    logic [2:0] erdi_cand_q;
    logic [3:0] erdi_cnt_q;
    logic [7:0] prev_lbl_q;
    logic [2:0] unst_cnt_q;
    logic [2:0] same_cnt_q;
    logic unstable_q;
    logic [15:0] bip_acc_q;
    logic [15:0] febe_acc_q;
    logic [15:0] bip_snap_q;
    logic [15:0] febe_snap_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    tpom_alarm_t alarm_q;
    logic irq_q;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire tu3 = own_q[OC_TU3];
    wire ext_sel = cs_q[CS_EXT_SEL];
    wire [3:0] filt_n = own_q[OC_FILT10] ? FILT_LONG : FILT_SHORT;
    wire tick = ovh.frame_tick;
    wire [9:0] idx = paddr[11:2];
    wire acc_phase = psel & penable;
    wire wr_ok = acc_phase & pready_q & pwrite & ~pslverr_q;
    wire rd_done = acc_phase & pready_q & ~pwrite;
    wire hit = (idx == IDX_AIS_CTRL) | (idx == IDX_CFG_STAT) | (idx == IDX_EXP_LABEL)
             | (idx == IDX_ACC_LABEL) | (idx == IDX_BIP_LO) | (idx == IDX_BIP_HI)
             | (idx == IDX_FEBE_LO) | (idx == IDX_FEBE_HI) | (idx == IDX_OWN_CTRL)
             | (idx == IDX_ACCUM_TRIG);
    wire snap = wr_ok & (idx == IDX_ACCUM_TRIG);

    // Remote defect source and run filter
    wire rdi_src = tu3 ? ovh.g1[3] : ovh.v5[0]; // [RULE_02] [RULE_10] [RULE_11]
    wire rfi_src = ovh.v5[4];
    wire rdi_filt_on = tick & ~ext_sel;
    wire rfi_filt_on = tick & ~ext_sel & ~tu3; // [RULE_03]
    wire [3:0] rdi_cnt_inc = rdi_cnt_q + 4'h1;
    wire [3:0] rfi_cnt_inc = rfi_cnt_q + 4'h1;
    wire rdi_flip = (rdi_src != rdi_q) & (rdi_cnt_inc >= filt_n); // [RULE_01] [RULE_02]
    wire rfi_flip = (rfi_src != rfi_q) & (rfi_cnt_inc >= filt_n); // [RULE_03]

    // Extended code source
    wire [2:0] erdi_src = tu3 ? ovh.g1[3:1] : ovh.z7[3:1]; // [RULE_10] [RULE_11]
    wire erdi_same = (erdi_src == erdi_cand_q);
    wire [3:0] erdi_cnt_inc = erdi_same ? erdi_cnt_q + 4'h1 : 4'h1;
    wire erdi_load = tick & ext_sel & (erdi_cnt_inc >= filt_n); // [RULE_04]

    // Label stability and acceptance
    wire [7:0] in_lbl = lbl_mask(tu3, ovh.label);
    wire lbl_diff = (in_lbl != prev_lbl_q);
    wire [2:0] same_inc = (same_cnt_q == SAME_LIMIT) ? SAME_LIMIT : same_cnt_q + 3'h1;
    wire stable_now = tick & ~lbl_diff & (same_inc == SAME_LIMIT);
    wire [2:0] unst_inc = (unst_cnt_q == UNSTABLE_LIMIT) ? UNSTABLE_LIMIT
                                                         : unst_cnt_q + 3'h1;
    wire mismatch = lbl_mask(tu3, exp_q) != lbl_mask(tu3, acc_q); // [RULE_05] [RULE_12]

    // Path defect and AIS
    wire pdi_hit = prev_lbl_q[2:0] == own_q[OC_PDI_LSB +: 3]; // [RULE_07]
    wire pdi_d = cs_q[CS_FORCE_PDI] | pdi_hit; // [RULE_07]
    wire ais_thru = (ovh.lop & aisc_q[AC_LOP]) | (ovh.lom & aisc_q[AC_LOM]); // [RULE_09]
    wire ais_term = ais_thru | (ovh.ais & aisc_q[AC_AIS])
                  | (mismatch & aisc_q[AC_PLM]) | (unstable_q & aisc_q[AC_PLU]);
    wire ais_d = cs_q[CS_TERM] ? ais_term : ais_thru; // [RULE_08] [RULE_09]

    // Error increments
    wire [7:0] bip_bits = tu3 ? ovh.bip_err : {6'h00, ovh.bip_err[1:0]}; // [RULE_17]
    wire [3:0] bip_inc_w = own_q[OC_BLOCK] ? {3'h0, |bip_bits} : ones8(bip_bits); // [RULE_18]
    wire [15:0] bip_inc = tick ? {12'h000, bip_inc_w} : 16'h0000;
    wire [15:0] febe_inc = tick ? {12'h000, ovh.febe} : 16'h0000;
    wire [15:0] cnt_mask = tu3 ? 16'hFFFF : LO_COUNT_MASK;

    // Status byte
    wire [2:0] low_stat = ext_sel ? erdi_q : {1'b0, rfi_q & ~tu3, rdi_q};
    wire [7:0] cs_rd = {cs_q[7:5], unstable_q, mismatch, low_stat};
    wire [7:0] own_rd = {irq_q, own_q[6:0]};

    // Read mux
    wire [7:0] rd_byte =
        (idx == IDX_AIS_CTRL) ? aisc_q :
        (idx == IDX_CFG_STAT) ? cs_rd :
        (idx == IDX_EXP_LABEL) ? exp_q :
        (idx == IDX_ACC_LABEL) ? lbl_mask(tu3, acc_q) : // [RULE_13]
        (idx == IDX_BIP_LO) ? bip_snap_q[7:0] :
        (idx == IDX_BIP_HI) ? bip_snap_q[15:8] :
        (idx == IDX_FEBE_LO) ? febe_snap_q[7:0] :
        (idx == IDX_FEBE_HI) ? febe_snap_q[15:8] :
        (idx == IDX_OWN_CTRL) ? own_rd : 8'h00;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc_phase & ~pready_q;
            pslverr_q <= acc_phase & ~pready_q & ~hit;
            prdata_q <= (acc_phase & ~pready_q & ~pwrite) ? {24'h000000, rd_byte}
                                                          : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cs_q <= CS_RESET;
            exp_q <= EXP_LABEL_RESET;
            own_q <= OWN_CTRL_RESET;
            aisc_q <= AIS_CTRL_RESET;
        end else if (wr_ok) begin
            if (idx == IDX_CFG_STAT) cs_q <= {pwdata[7:5], 5'h00};
            if (idx == IDX_EXP_LABEL) exp_q <= pwdata[7:0];
            if (idx == IDX_OWN_CTRL) own_q <= {1'b0, pwdata[6:0]};
            if (idx == IDX_AIS_CTRL) aisc_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Remote defect and failure filters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdi_q <= 1'b0;
            rdi_cnt_q <= 4'h0;
        end else if (rdi_filt_on) begin
            if (rdi_src == rdi_q) rdi_cnt_q <= 4'h0;
            else if (rdi_flip) begin
                rdi_q <= rdi_src; // [RULE_01] [RULE_02]
                rdi_cnt_q <= 4'h0;
            end else rdi_cnt_q <= rdi_cnt_inc;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rfi_q <= 1'b0;
            rfi_cnt_q <= 4'h0;
        end else if (rfi_filt_on) begin
            if (rfi_src == rfi_q) rfi_cnt_q <= 4'h0;
            else if (rfi_flip) begin
                rfi_q <= rfi_src; // [RULE_03]
                rfi_cnt_q <= 4'h0;
            end else rfi_cnt_q <= rfi_cnt_inc;
        end
    end

    // ------------------------------------------------------------
    // Extended remote defect code
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            erdi_q <= 3'h0;
            erdi_cand_q <= 3'h0;
            erdi_cnt_q <= 4'h0;
        end else if (tick & ext_sel) begin
            erdi_cand_q <= erdi_src;
            erdi_cnt_q <= erdi_load ? filt_n : erdi_cnt_inc;
            if (erdi_load) erdi_q <= erdi_src; // [RULE_04]
        end
    end

    // ------------------------------------------------------------
    // Label stability, acceptance
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_lbl_q <= 8'h00;
            unst_cnt_q <= 3'h0;
            same_cnt_q <= 3'h0;
            unstable_q <= 1'b0;
        end else if (tick) begin
            prev_lbl_q <= in_lbl;
            if (lbl_diff) begin
                unst_cnt_q <= unst_inc; // [RULE_06]
                same_cnt_q <= 3'h1;
                if (unst_inc == UNSTABLE_LIMIT) unstable_q <= 1'b1;
            end else begin
                same_cnt_q <= same_inc;
                if (same_inc == SAME_LIMIT) begin
                    unst_cnt_q <= 3'h0; // [RULE_06]
                    unstable_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) acc_q <= ACC_LABEL_RESET;
        else if (stable_now) acc_q <= in_lbl; // [RULE_13]
        else if (wr_ok & (idx == IDX_ACC_LABEL)) acc_q <= pwdata[7:0];
    end

    // ------------------------------------------------------------
    // Error counters and snapshot
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bip_acc_q <= 16'h0000;
            febe_acc_q <= 16'h0000;
            bip_snap_q <= 16'h0000;
            febe_snap_q <= 16'h0000;
        end else if (snap) begin
            bip_snap_q <= bip_acc_q & cnt_mask; // [RULE_14] [RULE_16] [RULE_21]
            febe_snap_q <= febe_acc_q & cnt_mask; // [RULE_19] [RULE_21]
            bip_acc_q <= bip_inc; // [RULE_14]
            febe_acc_q <= febe_inc; // [RULE_19]
        end else begin
            bip_acc_q <= bip_acc_q + bip_inc; // [RULE_15] [RULE_17]
            febe_acc_q <= febe_acc_q + febe_inc;
        end
    end

    // ------------------------------------------------------------
    // Alarm port and remote defect change flag
    // ------------------------------------------------------------
    wire rdi_change = rdi_filt_on & rdi_flip;
    wire erdi_change = erdi_load & (erdi_src != erdi_q);
    wire irq_clr = wr_ok & (idx == IDX_OWN_CTRL) & pwdata[OC_RDI_EVENT];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q <= '0;
            irq_q <= 1'b0;
        end else begin
            alarm_q.path_defect_indication <= pdi_d; // [RULE_07]
            alarm_q.remote_defect <= rdi_q & ~ext_sel;
            alarm_q.extended_remote_defect_code <= ext_sel ? erdi_q : 3'h0;
            alarm_q.ais_insert <= ais_d; // [RULE_08] [RULE_09]
            if ((rdi_change | erdi_change) & own_q[OC_RDI_IRQ_EN]) irq_q <= 1'b1; // [RULE_20]
            else if (irq_clr) irq_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign receive_alarm_port = alarm_q;
    assign remote_defect_irq = irq_q;

endmodule : tpom_monitor

`default_nettype wire

// File: tpom_pkg.sv
// Purpose: Constants and carriers for the tributary path overhead monitor
// Assumes: APB data is 32 bits; every register is one aligned word
// Notes: Register constants are word indices; byte address is four times the index
package tpom_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_AIS_CTRL = 10'h010;
    localparam logic [9:0] IDX_CFG_STAT = 10'h101;
    localparam logic [9:0] IDX_EXP_LABEL = 10'h102;
    localparam logic [9:0] IDX_ACC_LABEL = 10'h103;
    localparam logic [9:0] IDX_BIP_LO = 10'h104;
    localparam logic [9:0] IDX_BIP_HI = 10'h105;
    localparam logic [9:0] IDX_FEBE_LO = 10'h106;
    localparam logic [9:0] IDX_FEBE_HI = 10'h107;
    localparam logic [9:0] IDX_OWN_CTRL = 10'h110;
    localparam logic [9:0] IDX_ACCUM_TRIG = 10'h111;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CS_EXT_SEL = 7;
    localparam int CS_TERM = 6;
    localparam int CS_FORCE_PDI = 5;
    localparam int OC_TU3 = 0;
    localparam int OC_FILT10 = 1;
    localparam int OC_BLOCK = 2;
    localparam int OC_RDI_IRQ_EN = 3;
    localparam int OC_PDI_LSB = 4;
    localparam int OC_RDI_EVENT = 7;
    localparam int AC_LOP = 0;
    localparam int AC_LOM = 1;
    localparam int AC_AIS = 2;
    localparam int AC_PLM = 3;
    localparam int AC_PLU = 4;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CS_RESET = 8'h00;
    localparam logic [7:0] EXP_LABEL_RESET = 8'h00;
    localparam logic [7:0] ACC_LABEL_RESET = 8'h00;
    localparam logic [7:0] OWN_CTRL_RESET = 8'h00;
    localparam logic [7:0] AIS_CTRL_RESET = 8'h00;
    localparam logic [3:0] FILT_SHORT = 4'h5;
    localparam logic [3:0] FILT_LONG = 4'hA;
    localparam logic [2:0] UNSTABLE_LIMIT = 3'h5;
    localparam logic [2:0] SAME_LIMIT = 3'h5;
    localparam logic [15:0] LO_COUNT_MASK = 16'h07FF;
    localparam int SNAPSHOT_LIMIT_NS = 10000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SNAPSHOT_LIMIT_CYC = SNAPSHOT_LIMIT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic frame_tick;
        logic [7:0] v5;
        logic [7:0] z7;
        logic [7:0] g1;
        logic [7:0] label;
        logic [7:0] bip_err;
        logic [3:0] febe;
        logic lop;
        logic lom;
        logic ais;
    } tpom_ovh_t;

    typedef struct packed {
        logic path_defect_indication;
        logic remote_defect;
        logic [2:0] extended_remote_defect_code;
        logic ais_insert;
    } tpom_alarm_t;

endpackage : tpom_pkg

// File: tpom_checker.sv
// Purpose: Port assertions for the path overhead monitor
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the monitor below the module
`timescale 1ns/1ps
`default_nettype none
module tpom_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tpom_pkg::tpom_ovh_t ovh,
    input wire tpom_pkg::tpom_alarm_t receive_alarm_port,
    input wire logic remote_defect_irq
);
    import tpom_pkg::*;
    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire logic done = psel && penable && pready;
    wire logic wr_own = done && pwrite && paddr[11:2] == IDX_OWN_CTRL;
    wire logic wr_cfg = done && pwrite && paddr[11:2] == IDX_CFG_STAT;
    wire logic mapped = paddr[11:2] inside {IDX_AIS_CTRL, IDX_CFG_STAT, IDX_EXP_LABEL,
        IDX_ACC_LABEL, IDX_BIP_LO, IDX_BIP_HI, IDX_FEBE_LO, IDX_FEBE_HI, IDX_OWN_CTRL,
        IDX_ACCUM_TRIG};
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    a_rdata_upper: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("error response mismatch");
    a_force_pdi: assert property (
        wr_cfg && pwdata[CS_FORCE_PDI] |-> ##[1:3] receive_alarm_port.path_defect_indication)
        else $error("forced defect indication missing");
    a_code_excl: assert property (
        receive_alarm_port.remote_defect |-> receive_alarm_port.extended_remote_defect_code == 3'h0)
        else $error("plain and extended defect together");
    a_irq_sticky: assert property (remote_defect_irq && !wr_own |=> remote_defect_irq)
        else $error("event flag dropped");
    a_irq_clear: assert property (
        wr_own && pwdata[OC_RDI_EVENT] && !ovh.frame_tick |=> ##[0:1] !remote_defect_irq)
        else $error("event flag not cleared");
endmodule : tpom_checker
bind tpom_monitor tpom_checker tpom_checker_i (.clk_sys, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ovh, .receive_alarm_port, .remote_defect_irq);
`default_nettype wire

// File: tpom_ovh_source.sv
// Purpose: Incoming overhead stream source
// Assumes: One tick cycle, then one idle cycle per frame
// Notes: Idle fields carry the inverse of the last frame
`timescale 1ns/1ps
`default_nettype none
module tpom_ovh_source (
    input wire logic clk_sys,
    output var tpom_pkg::tpom_ovh_t ovh
);
    import tpom_pkg::*;
    // ------------------------------------------------------------
    // Frame and alarm drive
    // ------------------------------------------------------------
    initial ovh = '0;
    task automatic send(input logic [7:0] v5, z7, g1, lb, bip, input logic [3:0] fb);
        @(posedge clk_sys);
        ovh <= '{1'b1, v5, z7, g1, lb, bip, fb, ovh.lop, ovh.lom, ovh.ais};
        @(posedge clk_sys);
        ovh <= '{1'b0, ~v5, ~z7, ~g1, ~lb, ~bip, ~fb, ovh.lop, ovh.lom, ovh.ais};
    endtask : send
    task automatic set_alarms(input logic [2:0] a);
        @(posedge clk_sys);
        {ovh.lop, ovh.lom, ovh.ais} <= a;
    endtask : set_alarms
endmodule : tpom_ovh_source
`default_nettype wire

// File: tpom_monitor_tb_top.sv
// Purpose: Self-checking bench for the path overhead monitor
// Assumes: APB master with one request in flight
// Notes: Reads are noted in a queue and compared by a watcher
`timescale 1ns/1ps
`default_nettype none
module tpom_monitor_tb_top;
    import tpom_pkg::*;
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, remote_defect_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    tpom_ovh_t ovh;
    tpom_alarm_t alm;
    int n_errors = 0;
    int compares = 0;
    int n;
    logic [32:0] exp_q[$];
    logic [2:0] lab, code;
    tpom_monitor tpom_monitor_i (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ovh, .receive_alarm_port(alm), .remote_defect_irq);
    tpom_ovh_source tpom_ovh_source_i (.clk_sys, .ovh);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        bit ok;
        ok = 1'b0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int k = 0; k < 16 && !ok; k++) begin
            @(posedge clk_sys);
            ok = pready;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic err = 1'b0);
        exp_q.push_back({err, 24'h0, e});
        apb(1'b0, idx, 8'h00);
    endtask : rd
    task automatic frames(input int c, input logic [7:0] v5, z7, g1, lb, bip,
                          input logic [3:0] fb);
        repeat (c) tpom_ovh_source_i.send(v5, z7, g1, lb, bip, fb);
    endtask : frames
    task automatic ais_case(input logic [7:0] cfg, ctl, input logic [2:0] a, input logic e);
        wr(IDX_CFG_STAT, cfg);
        wr(IDX_AIS_CTRL, ctl);
        tpom_ovh_source_i.set_alarms(a);
        repeat (3) @(posedge clk_sys);
        check("ais_insert", alm.ais_insert, e);
    endtask : ais_case
    task automatic counts(input logic [15:0] b, f);
        rd(IDX_BIP_LO, b[7:0]);
        rd(IDX_BIP_HI, b[15:8]);
        rd(IDX_FEBE_LO, f[7:0]);
        rd(IDX_FEBE_HI, f[15:8]);
    endtask : counts
    // ------------------------------------------------------------
    // Clock, watcher and sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_errors++;
            end else begin
                check("read", {pslverr, prdata}, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        n = $urandom(32'hE335);
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(IDX_CFG_STAT, CS_RESET);
        rd(IDX_ACC_LABEL, ACC_LABEL_RESET);
        rd(IDX_EXP_LABEL, EXP_LABEL_RESET);
        rd(IDX_ACCUM_TRIG, 8'h00);
        rd(10'h0FF, 8'h00, 1'b1);
        wr(10'h0FF, 8'hFF);
        wr(IDX_OWN_CTRL, 8'h08);
        frames(4, 8'h11, 0, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h00);
        frames(1, 8'h11, 0, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h03);
        check("remote_defect", alm.remote_defect, 1'b1);
        check("irq", remote_defect_irq, 1'b1);
        wr(IDX_OWN_CTRL, 8'h8A);
        @(posedge clk_sys);
        check("irq", remote_defect_irq, 1'b0);
        frames(9, 0, 0, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h03);
        frames(1, 0, 0, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h00);
        check("irq", remote_defect_irq, 1'b1);
        wr(IDX_OWN_CTRL, 8'h01);
        frames(5, 8'h10, 0, 8'h08, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h01);
        frames(5, 8'h10, 0, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h00);
        code = 3'($urandom % 6 + 1);
        wr(IDX_CFG_STAT, 8'h80);
        wr(IDX_OWN_CTRL, 8'h00);
        frames(4, 0, {4'h0, code, 1'b0}, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, 8'h80);
        frames(1, 0, {4'h0, code, 1'b0}, 0, 0, 0, 0);
        rd(IDX_CFG_STAT, {5'h10, code});
        check("ext_code", alm.extended_remote_defect_code, code);
        wr(IDX_OWN_CTRL, 8'h01);
        frames(5, 0, 0, {4'h0, ~code, 1'b0}, 0, 0, 0);
        rd(IDX_CFG_STAT, {5'h10, ~code});
        wr(IDX_CFG_STAT, 8'h00);
        frames(5, 0, 0, 0, 0, 0, 0);
        wr(IDX_OWN_CTRL, 8'h00);
        lab = 3'($urandom % 7 + 1);
        frames(5, 0, 0, 0, {5'h0, lab}, 0, 0);
        rd(IDX_ACC_LABEL, {5'h0, lab});
        rd(IDX_CFG_STAT, 8'h08);
        wr(IDX_EXP_LABEL, {5'h1F, lab});
        rd(IDX_CFG_STAT, 8'h00);
        wr(IDX_OWN_CTRL, 8'h01);
        rd(IDX_CFG_STAT, 8'h08);
        wr(IDX_OWN_CTRL, 8'h00);
        for (int i = 1; i <= 5; i++) begin
            frames(1, 0, 0, 0, {5'h0, 3'(lab + i)}, 0, 0);
            if (i == 4) begin
                rd(IDX_CFG_STAT, 8'h00);
            end
        end
        rd(IDX_CFG_STAT, 8'h10);
        frames(4, 0, 0, 0, {5'h0, lab}, 0, 0);
        rd(IDX_CFG_STAT, 8'h10);
        frames(1, 0, 0, 0, {5'h0, lab}, 0, 0);
        rd(IDX_CFG_STAT, 8'h00);
        wr(IDX_OWN_CTRL, {1'b0, lab, 4'h0});
        repeat (2) @(posedge clk_sys);
        check("pdi", alm.path_defect_indication, 1'b1);
        frames(1, 0, 0, 0, {5'h0, ~lab}, 0, 0);
        repeat (2) @(posedge clk_sys);
        check("pdi", alm.path_defect_indication, 1'b0);
        wr(IDX_CFG_STAT, 8'h20);
        repeat (2) @(posedge clk_sys);
        check("pdi", alm.path_defect_indication, 1'b1);
        ais_case(8'h00, 8'h1F, 3'b001, 1'b0);
        ais_case(8'h00, 8'h1F, 3'b100, 1'b1);
        ais_case(8'h00, 8'h1F, 3'b010, 1'b1);
        ais_case(8'h00, 8'h1C, 3'b100, 1'b0);
        ais_case(8'h40, 8'h1F, 3'b001, 1'b1);
        ais_case(8'h40, 8'h1B, 3'b001, 1'b0);
        tpom_ovh_source_i.set_alarms(3'b000);
        wr(IDX_CFG_STAT, 8'h00);
        wr(IDX_OWN_CTRL, 8'h00);
        wr(IDX_ACCUM_TRIG, 8'h00);
        n = 1100 + ($urandom % 50);
        frames(n, 0, 0, 0, {5'h0, lab}, 8'hFF, 4'h3);
        wr(IDX_ACCUM_TRIG, 8'h5A);
        counts(16'(2 * n) & LO_COUNT_MASK, 16'(3 * n) & LO_COUNT_MASK);
        wr(IDX_OWN_CTRL, 8'h04);
        frames(7, 0, 0, 0, {5'h0, lab}, 8'h02, 4'h1);
        frames(3, 0, 0, 0, {5'h0, lab}, 8'h03, 4'h0);
        wr(IDX_ACCUM_TRIG, 8'h00);
        counts(16'h000A, 16'h0007);
        wr(IDX_ACCUM_TRIG, 8'h00);
        counts(16'h0000, 16'h0000);
        wr(IDX_OWN_CTRL, 8'h01);
        frames(8200, 0, 0, 0, {5'h0, lab}, 8'hFF, 4'hF);
        wr(IDX_ACCUM_TRIG, 8'h00);
        counts(16'(8 * 8200), 16'(15 * 8200));
        tally_and_finish();
    end
endmodule : tpom_monitor_tb_top
`default_nettype wire
